// [hdl/eth_power_save_pkg.sv]
// Constants and state type for the Ethernet power-save sequencer.
package eth_power_save_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned WAKE_SETTLE_MS  = 500;
  localparam int unsigned WAKE_SETTLE_CYC = (WAKE_SETTLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RESET_CYC  = 2;
  localparam int unsigned WAKE_CNT_W      = 24;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] NET_OUT_RESET   = 8'h00;
  localparam logic [7:0] BUS_CFG_RESET   = 8'h00;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [4:0] {
    ST_RUN       = 5'h01,
    ST_WAIT_GNT  = 5'h02,
    ST_SOFT_RST  = 5'h04,
    ST_SLEEP     = 5'h08,
    ST_WAKE      = 5'h10
  } seq_state_t;

endpackage : eth_power_save_pkg

// [hdl/bit_rate_divider.sv]
// Divide-by-two enable that gives the network bit rate from the oscillator.
`timescale 1ns/100ps
`default_nettype none

module bit_rate_divider
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  // Bit-rate enable
  output logic      bitEn
);

  logic phase_q;
  logic phase_d;

  always_comb
  begin
    phase_d = run ? ~phase_q : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_q <= 1'b0;
    else
      phase_q <= phase_d;
  end

  assign bitEn = phase_q;

endmodule : bit_rate_divider

`default_nettype wire

// [hdl/ethernet_power_save_control.sv]
// Power-save sequencer for the Ethernet section, with its assertions.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - A low power-save request first runs a soft reset and then enters the reduced-power state.
// - That soft reset leaves the bus configuration registers untouched.
// - In power save the PCI side keeps running and configuration space stays readable and writable.
// - An I/O access aimed at the device during power save ends in a target abort.
// - The bus request is never asserted while in power save.
// - In power save the network outputs hold their soft-reset values and network inputs are ignored.
// - Releasing the request wakes the device and network work waits 0.5 s after that release.
// - A request that arrives with the bus request out waits for grant, drops the request, then sleeps.
// - The power-save request has no effect on the SCSI section.
// - The network bit rate is half the 10 MHz oscillator frequency.
// - Once out, the Ethernet bus request stays out until grant, whatever follows.
// - The hardware reset pin gives a full reset and is held at least 30 clock periods.
module ethernet_power_save_control
#(
  parameter int unsigned WAKE_CYCLES = eth_power_save_pkg::WAKE_SETTLE_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Power-save request pin
  input  wire logic       powerSaveReq_n,
  // Bus master handshake
  input  wire logic       busMasterWant,
  input  wire logic       grant_n,
  output logic            ethernet_bus_request_n,
  // Slave decode from the PCI interface
  input  wire logic       ioAccess,
  input  wire logic       cfgAccess,
  output logic            targetAbort,
  output logic            cfgAccessOk,
  // Bus configuration register write port
  input  wire logic       cfgWrite,
  input  wire logic [7:0] cfgWriteData,
  output logic [7:0]      bus_config_registers,
  // Network side
  input  wire logic [7:0] netIn,
  input  wire logic [7:0] netOutCore,
  output logic [7:0]      netIn_gated,
  output logic [7:0]      netOut,
  output logic            netBitEn,
  // Status
  output logic            softReset,
  output logic            sleeping,
  output logic            netReady,
  // SCSI section passes straight through
  input  wire logic       scsiActiveIn,
  output logic            scsiActive
);

  // ==========================================================================
  // Request synchroniser
  // ==========================================================================
  logic syncA_q;
  logic syncB_q;
  logic sleepReq;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
    end
    else
    begin
      syncA_q <= powerSaveReq_n;
      syncB_q <= syncA_q;
    end
  end

  assign sleepReq = ~syncB_q;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  eth_power_save_pkg::seq_state_t state_q;
  eth_power_save_pkg::seq_state_t state_d;
  logic                           req_q;
  logic                           req_d;
  logic [1:0]                     srCnt_q;
  logic [1:0]                     srCnt_d;
  localparam int unsigned WAKE_CNT_W = eth_power_save_pkg::WAKE_CNT_W;
  logic [eth_power_save_pkg::WAKE_CNT_W-1:0] wakeCnt_q;
  logic [eth_power_save_pkg::WAKE_CNT_W-1:0] wakeCnt_d;
  logic                           granted;

  assign granted = ~grant_n;

  always_comb
  begin
    state_d   = state_q;
    req_d     = req_q;
    srCnt_d   = srCnt_q;
    wakeCnt_d = wakeCnt_q;
    if (req_q && granted)
      req_d = 1'b0;
    unique case (state_q)
      eth_power_save_pkg::ST_RUN:
      begin
        if (sleepReq)
        begin
          if (req_q && !granted)
            state_d = eth_power_save_pkg::ST_WAIT_GNT;
          else
          begin
            state_d = eth_power_save_pkg::ST_SOFT_RST;
            srCnt_d = 2'(eth_power_save_pkg::SOFT_RESET_CYC);
            req_d   = 1'b0;
          end
        end
        else if (!req_q && busMasterWant)
          req_d = 1'b1;
      end
      eth_power_save_pkg::ST_WAIT_GNT:
      begin
        if (granted)
        begin
          state_d = eth_power_save_pkg::ST_SOFT_RST;
          srCnt_d = 2'(eth_power_save_pkg::SOFT_RESET_CYC);
        end
      end
      eth_power_save_pkg::ST_SOFT_RST:
      begin
        if (srCnt_q == 2'h1)
          state_d = eth_power_save_pkg::ST_SLEEP;
        srCnt_d = srCnt_q - 2'h1;
      end
      eth_power_save_pkg::ST_SLEEP:
      begin
        if (!sleepReq)
        begin
          state_d   = eth_power_save_pkg::ST_WAKE;
          wakeCnt_d = WAKE_CNT_W'(WAKE_CYCLES);
        end
      end
      eth_power_save_pkg::ST_WAKE:
      begin
        if (sleepReq)
        begin
          state_d = eth_power_save_pkg::ST_SOFT_RST;
          srCnt_d = 2'(eth_power_save_pkg::SOFT_RESET_CYC);
        end
        else if (wakeCnt_q <= 24'h000001)
          state_d = eth_power_save_pkg::ST_RUN;
        else
          wakeCnt_d = wakeCnt_q - 24'h000001;
      end
      default:
        state_d = eth_power_save_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= eth_power_save_pkg::ST_RUN;
      req_q     <= 1'b0;
      srCnt_q   <= 2'h0;
      wakeCnt_q <= '0;
    end
    else
    begin
      state_q   <= state_d;
      req_q     <= req_d;
      srCnt_q   <= srCnt_d;
      wakeCnt_q <= wakeCnt_d;
    end
  end

  logic inSleep;
  logic holdNet;

  assign inSleep   = (state_q == eth_power_save_pkg::ST_SLEEP);
  assign holdNet   = inSleep || (state_q == eth_power_save_pkg::ST_SOFT_RST);
  assign softReset = (state_q == eth_power_save_pkg::ST_SOFT_RST);
  assign sleeping  = inSleep;
  assign netReady  = (state_q == eth_power_save_pkg::ST_RUN);

  assign ethernet_bus_request_n = ~(req_q && !inSleep);

  assign targetAbort = ioAccess && inSleep;

  assign cfgAccessOk = cfgAccess;

  assign scsiActive = scsiActiveIn;

  // ==========================================================================
  // Bus configuration registers
  // ==========================================================================
  logic [7:0] bcfg_q;
  logic [7:0] bcfg_d;

  always_comb
  begin
    bcfg_d = cfgWrite ? cfgWriteData : bcfg_q;
  end

  // full reset on the reset pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bcfg_q <= eth_power_save_pkg::BUS_CFG_RESET;
    else
      bcfg_q <= bcfg_d;
  end

  assign bus_config_registers = bcfg_q;

  // ==========================================================================
  // Network side
  // ==========================================================================
  logic [7:0] netOut_q;
  logic [7:0] netOut_d;

  always_comb
  begin
    netOut_d = holdNet ? eth_power_save_pkg::NET_OUT_RESET : netOutCore;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      netOut_q <= eth_power_save_pkg::NET_OUT_RESET;
    else
      netOut_q <= netOut_d;
  end

  assign netOut      = netOut_q;
  assign netIn_gated = holdNet ? 8'h00 : netIn;

  bit_rate_divider u_div
  (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (!holdNet),
    .bitEn (netBitEn)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_enterReq;
    $fell(syncB_q) && netReady && !req_q;
  endsequence

  sequence s_softThenSleep;
    softReset [*2] ##1 sleeping;
  endsequence

  a_entry_order: assert property (@(posedge clk) disable iff (!rst_n)
    s_enterReq |=> s_softThenSleep)
    else $error("soft reset did not precede sleep");

  a_no_req_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    sleeping |-> ethernet_bus_request_n)
    else $error("bus request asserted while asleep");

  a_abort_io: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && ioAccess) |-> targetAbort)
    else $error("I/O access not aborted in sleep");

  a_cfg_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (softReset && !cfgWrite) |=> $stable(bus_config_registers))
    else $error("configuration changed by soft reset");

  a_cfg_open: assert property (@(posedge clk) disable iff (!rst_n)
    cfgAccess |-> cfgAccessOk)
    else $error("configuration access blocked");

  a_net_hold: assert property (@(posedge clk) disable iff (!rst_n)
    sleeping |-> (netOut == 8'h00) && (netIn_gated == 8'h00))
    else $error("network pins not held in sleep");

  a_wait_grant: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == eth_power_save_pkg::ST_WAIT_GNT && grant_n) |=> !softReset && !sleeping)
    else $error("sleep entered before grant");

  a_req_held: assert property (@(posedge clk) disable iff (!rst_n)
    (!ethernet_bus_request_n && grant_n && !sleeping) |=> (!ethernet_bus_request_n || sleeping))
    else $error("bus request dropped before grant");

  a_wake_start: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && syncB_q) |=> (state_q == eth_power_save_pkg::ST_WAKE) && !netReady)
    else $error("wake did not start on release");

  a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(powerSaveReq_n) && netReady && !req_q |=> !softReset)
    else $error("request acted on without synchronisation");

  a_scsi_pass: assert property (@(posedge clk) disable iff (!rst_n)
    scsiActive == scsiActiveIn)
    else $error("SCSI path affected");

  a_bit_rate: assert property (@(posedge clk) disable iff (!rst_n)
    (netBitEn && !holdNet) |=> !netBitEn)
    else $error("bit enable faster than half rate");

endmodule : ethernet_power_save_control

`default_nettype wire

// [bench/pci_arbiter_model.sv]
// Bus arbiter model that grants the Ethernet bus request after a set delay.
`timescale 1ns/100ps
`default_nettype none

module pci_arbiter_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Arbitration
  input  wire logic       busReq_n,
  input  wire logic [7:0] grantDelay,
  output logic            grant_n
);
  // ==========================================================================
  // Grant timing
  // ==========================================================================
  logic [7:0] waitCnt_q;

  // clock kept running
  // Grant is held until the request drops, as a real arbiter would.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitCnt_q <= 8'h00;
      grant_n   <= 1'b1;
    end
    else if (busReq_n)
    begin
      waitCnt_q <= 8'h00;
      grant_n   <= 1'b1;
    end
    else if (waitCnt_q >= grantDelay)
      grant_n <= 1'b0;
    else
      waitCnt_q <= waitCnt_q + 8'h01;
  end
endmodule : pci_arbiter_model

`default_nettype wire

// [bench/ethernet_power_save_control_tb.sv]
// Self-checking testbench for the Ethernet power-save sequencer.
`timescale 1ns/100ps
`default_nettype none

module ethernet_power_save_control_tb;
  localparam int unsigned WAKE = 10;
  logic       clk, rst_n, pinReq_n, want, grant_n, reqOut_n, ioAcc, cfgAcc;
  logic       abort, cfgOk, cfgWr, bitEn, softRst, sleeping, netReady, scsiIn, scsiOut;
  logic [7:0] cfgData, cfgRegs, netIn, netCore, netGated, netOut, grantDelay;
  int         errTotal, testsRun;

  // ==========================================================================
  // Instances
  // ==========================================================================
  ethernet_power_save_control #(.WAKE_CYCLES(WAKE)) u_dut (
    .clk(clk), .rst_n(rst_n), .powerSaveReq_n(pinReq_n), .busMasterWant(want),
    .grant_n(grant_n), .ethernet_bus_request_n(reqOut_n), .ioAccess(ioAcc),
    .cfgAccess(cfgAcc), .targetAbort(abort), .cfgAccessOk(cfgOk), .cfgWrite(cfgWr),
    .cfgWriteData(cfgData), .bus_config_registers(cfgRegs), .netIn(netIn),
    .netOutCore(netCore), .netIn_gated(netGated), .netOut(netOut), .netBitEn(bitEn),
    .softReset(softRst), .sleeping(sleeping), .netReady(netReady),
    .scsiActiveIn(scsiIn), .scsiActive(scsiOut));

  pci_arbiter_model u_arb (.clk(clk), .rst_n(rst_n), .busReq_n(reqOut_n),
    .grantDelay(grantDelay), .grant_n(grant_n));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic printVerdict();
    if (errTotal == 0 && testsRun > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : printVerdict

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic testReset();
    @(negedge clk);
    chk("rst", {netReady, sleeping, softRst, reqOut_n, 4'h0}, 8'h90);
    chk("rst cfg", cfgRegs, 8'h00);
    chk("rst out", netOut, 8'h00);
  endtask : testReset

  task automatic testBitRate();
    int n;
    n = 0;
    repeat (20)
    begin
      @(negedge clk);
      if (bitEn === 1'b1)
        n++;
    end
    chk("rate", 8'(n), 8'h0a);
  endtask : testBitRate

  task automatic testSleep();
    int n;
    @(posedge clk);
    cfgWr <= 1'b1; cfgData <= 8'h5a; netCore <= 8'ha5; netIn <= 8'h3c;
    @(posedge clk);
    cfgWr <= 1'b0; pinReq_n <= 1'b0;
    @(negedge clk);
    chk("run out", netOut, 8'ha5);
    chk("run in", netGated, 8'h3c);
    chk("no sync", {7'h0, softRst}, 8'h00);
    n = 0;
    while (softRst !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk("soft", {7'h0, softRst}, 8'h01);
    chk("keep cfg", cfgRegs, 8'h5a);
    @(negedge clk);
    chk("soft2", {6'h0, softRst, sleeping}, 8'h02);
    // The network outputs are registered, so the forced value shows one cycle into soft reset.
    chk("held out", netOut, 8'h00);
    @(negedge clk);
    chk("asleep", {6'h0, softRst, sleeping}, 8'h01);
    @(posedge clk);
    ioAcc <= 1'b1; cfgAcc <= 1'b1; cfgWr <= 1'b1; cfgData <= 8'hc3; want <= 1'b1; scsiIn <= 1'b1;
    @(negedge clk);
    chk("abort", {abort, cfgOk, reqOut_n, scsiOut, bitEn, 3'h0}, 8'hf0);
    chk("gated", netGated, 8'h00);
    @(posedge clk);
    ioAcc <= 1'b0; cfgAcc <= 1'b0; cfgWr <= 1'b0; scsiIn <= 1'b0;
    @(negedge clk);
    chk("cfg wr", cfgRegs, 8'hc3);
    chk("idle", {abort, reqOut_n, scsiOut, sleeping, 4'h0}, 8'h50);
    @(posedge clk);
    want <= 1'b0;
  endtask : testSleep

  task automatic testWake();
    int n;
    @(posedge clk);
    pinReq_n <= 1'b1;
    n = 0;
    while (netReady !== 1'b1 && n < WAKE + 8)
    begin
      @(negedge clk);
      n++;
    end
    chk("wake", {7'h0, n >= WAKE && n <= WAKE + 5}, 8'h01);
    chk("ready", {sleeping, netReady, 6'h0}, 8'h40);
    chk("cfg after", cfgRegs, 8'hc3);
  endtask : testWake

  task automatic testBus(input logic [7:0] dly, input logic sleepToo);
    int n;
    @(posedge clk);
    grantDelay <= dly; want <= 1'b1;
    n = 0;
    while (reqOut_n !== 1'b0 && n < 5)
    begin
      @(negedge clk);
      n++;
    end
    chk("req", {7'h0, reqOut_n}, 8'h00);
    @(posedge clk);
    want <= 1'b0;
    if (sleepToo)
      pinReq_n <= 1'b0;
    n = 0;
    while (grant_n !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      chk("hold", {5'h0, softRst, sleeping, reqOut_n}, 8'h00);
      n++;
    end
    repeat (2) @(negedge clk);
    chk("drop", {7'h0, reqOut_n}, 8'h01);
    if (sleepToo)
    begin
      n = 0;
      while (sleeping !== 1'b1 && n < 10)
      begin
        @(negedge clk);
        n++;
      end
      chk("gnt sleep", {7'h0, sleeping}, 8'h01);
    end
  endtask : testBus

  task automatic testRewake();
    int n;
    @(posedge clk);
    pinReq_n <= 1'b1;
    n = 0;
    while (sleeping !== 1'b0 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    // Request again while the wake count is still running.
    @(posedge clk);
    pinReq_n <= 1'b0;
    n = 0;
    while (softRst !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      chk("no run", {7'h0, netReady}, 8'h00);
      n++;
    end
    chk("resleep", {softRst, netReady, 6'h0}, 8'h80);
    repeat (2) @(negedge clk);
    chk("asleep2", {7'h0, sleeping}, 8'h01);
  endtask : testRewake

  task automatic doReset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (30) @(posedge clk);
    testReset();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    testBitRate();
  endtask : doReset

  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  // clock never stops
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    errTotal++;
    printVerdict();
  end

  initial
  begin
    errTotal = 0; testsRun = 0; rst_n = 1'b0; pinReq_n = 1'b1; want = 1'b0;
    ioAcc = 1'b0; cfgAcc = 1'b0; cfgWr = 1'b0; cfgData = 8'h00; netIn = 8'h00;
    netCore = 8'h00; scsiIn = 1'b0; grantDelay = 8'h02;
    doReset();
    testSleep();
    testWake();
    testBitRate();
    testBus(8'h02, 1'b0);
    testBus(8'h14, 1'b1);
    testRewake();
    testWake();
    doReset();
    printVerdict();
  end
endmodule : ethernet_power_save_control_tb

`default_nettype wire
